// [sba_arbiter.sv]
// Purpose: Bit time measurement and single-wire bus arbitration counter
//          for a serial interface, with an Avalon-MM register slave.
// Assumes: rxd_in is a pin; the other inputs come from mclk_in logic.
// Notes:   Behaviour
`default_nettype none
`include "sba_defines.svh"

module sba_arbiter #(
   parameter int BUS_DIV = `SBA_BUS_DIV
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic rxd_in,
   input wire logic transmit_shift_in,
   input wire logic prescaler_tick_in,
   output logic txd_out,
   output logic irq_out
);

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   function automatic logic sba_hit(input logic [3:0] addr,
                                    input logic [3:0] off);
      sba_hit = (addr == off);
   endfunction

   logic wait_r;
   logic bus_req;
   logic acc;
   logic wr_any;
   logic wr_ctl;
   logic wr_stat;
   logic wr_mask;

   assign bus_req = avs_read_in | avs_write_in;
   // The access completes at the edge where waitrequest is seen low.
   assign acc = bus_req & ~wait_r;
   assign wr_any = acc & avs_write_in & avs_byteenable_in[0];
   assign wr_ctl = wr_any & sba_hit(avs_address_in, `SBA_OFF_CTL);
   assign wr_stat = wr_any & sba_hit(avs_address_in, `SBA_OFF_IRQ_STAT);
   assign wr_mask = wr_any & sba_hit(avs_address_in, `SBA_OFF_IRQ_MASK);

   // -------------------------------------------------------------------
   // Registers and state
   // -------------------------------------------------------------------
   sba_pkg::sba_mode_t mode;
   logic aclk;
   logic fin;
   logic ovf;
   logic lost;
   logic [8:0] cnt;
   sba_pkg::sba_state_t state;
   logic sampled;
   logic rx_low_seen;
   logic [`SBA_IRQ_W-1:0] irq_stat;
   logic [`SBA_IRQ_W-1:0] irq_mask;

   // -------------------------------------------------------------------
   // Receive pin synchroniser
   // -------------------------------------------------------------------
   logic rx_s1;
   logic rx_s2;
   logic rx_s3;
   logic rx_filt;
   logic rx_prev;
   logic rx_fall;
   logic rx_rise;

   // Stages two and three must agree, so one metastable sample is ignored.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
         rx_filt <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_s1 <= rxd_in;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) begin
            rx_filt <= rx_s3;
         end
         rx_prev <= rx_filt;
      end
   end

   assign rx_fall = rx_prev & ~rx_filt;
   assign rx_rise = ~rx_prev & rx_filt;

   // -------------------------------------------------------------------
   // Transmit shift edges
   // -------------------------------------------------------------------
   logic tx_prev;
   logic tx_rise;
   logic tx_fall;
   logic [`SBA_ECHO_W-1:0] tx_echo;

   // Delays our own pin like the receive path, to mask our own echo.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         tx_prev <= 1'b1;
         tx_echo <= '1;
      end else begin
         tx_prev <= transmit_shift_in;
         tx_echo <= {tx_echo[`SBA_ECHO_W-2:0], txd_out};
      end
   end

   assign tx_rise = ~tx_prev & transmit_shift_in;
   assign tx_fall = tx_prev & ~transmit_shift_in;

   // -------------------------------------------------------------------
   // Counter clock enables
   // -------------------------------------------------------------------
   localparam int DIV_W = (BUS_DIV > 1) ? $clog2(BUS_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_DIV - 1);
   logic [DIV_W-1:0] div_cnt;
   logic pre_half;
   logic cnt_tick;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         div_cnt <= '0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pre_half <= 1'b0;
      end else if (prescaler_tick_in) begin
         pre_half <= ~pre_half;
      end
   end

   assign cnt_tick = aclk ? (prescaler_tick_in & pre_half)
                          : (div_cnt == DIV_LAST);

   // -------------------------------------------------------------------
   // Events
   // -------------------------------------------------------------------
   logic counting;
   logic cnt_step;
   logic fin_evt;
   logic ovf_evt;
   logic lost_evt;
   logic [8:0] sample_pt;

   assign counting = (state == sba_pkg::SBA_COUNT);
   assign cnt_step = counting & cnt_tick;
   assign sample_pt = aclk ? `SBA_SAMPLE_PRE : `SBA_SAMPLE_BUS;

   assign fin_evt = counting & (mode == `SBA_MODE_MEAS)
                    & (aclk ? rx_rise : rx_fall);
   assign ovf_evt = cnt_step & (cnt == `SBA_CNT_MAX);
   assign lost_evt = counting & (mode == `SBA_MODE_ARB) & ~sampled
                     & (cnt == sample_pt) & ~rx_filt;

   // -------------------------------------------------------------------
   // Counter sequencing
   // -------------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state <= sba_pkg::SBA_IDLE;
         cnt <= `SBA_CNT_ZERO;
         sampled <= 1'b0;
         rx_low_seen <= 1'b0;
      end else if (wr_ctl) begin
         cnt <= `SBA_CNT_ZERO;
         sampled <= 1'b0;
         rx_low_seen <= 1'b0;
         if (avs_writedata_in[`SBA_BIT_MODE_UPPER]
             ^ avs_writedata_in[`SBA_BIT_MODE_LOWER]) begin
            state <= sba_pkg::SBA_ARMED;
         end else begin
            state <= sba_pkg::SBA_IDLE;
         end
      end else begin
         case (mode)
            `SBA_MODE_MEAS: begin
               case (state)
                  sba_pkg::SBA_ARMED: begin
                     cnt <= `SBA_CNT_ZERO;
                     if (aclk ? ~rx_filt : rx_fall) begin
                        state <= sba_pkg::SBA_COUNT;
                     end
                  end
                  sba_pkg::SBA_COUNT: begin
                     if (fin_evt) begin
                        state <= sba_pkg::SBA_STOPPED;
                     end else if (cnt_step) begin
                        cnt <= cnt + 9'h001;
                     end
                  end
                  sba_pkg::SBA_STOPPED: begin
                     state <= sba_pkg::SBA_STOPPED;
                  end
                  default: begin
                     state <= sba_pkg::SBA_ARMED;
                  end
               endcase
            end
            `SBA_MODE_ARB: begin
               if (tx_rise) begin
                  state <= sba_pkg::SBA_COUNT;
                  cnt <= `SBA_CNT_ZERO;
                  sampled <= 1'b0;
                  rx_low_seen <= 1'b0;
               end else if (counting & tx_fall & ~rx_low_seen) begin
                  state <= sba_pkg::SBA_ARMED;
                  cnt <= `SBA_CNT_ZERO;
                  sampled <= 1'b0;
               end else if (counting) begin
                  if (~rx_filt & (&tx_echo)) begin
                     rx_low_seen <= 1'b1;
                  end
                  if (cnt == sample_pt) begin
                     sampled <= 1'b1;
                  end
                  if (cnt_step) begin
                     cnt <= cnt + 9'h001;
                  end
               end
            end
            default: begin
               state <= sba_pkg::SBA_IDLE;
               cnt <= `SBA_CNT_ZERO;
               sampled <= 1'b0;
               rx_low_seen <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Control fields and flags
   // -------------------------------------------------------------------
   // mode field store
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         mode <= `SBA_MODE_IDLE;
         aclk <= 1'b0;
      end else if (wr_ctl) begin
         mode <= {avs_writedata_in[`SBA_BIT_MODE_UPPER],
                  avs_writedata_in[`SBA_BIT_MODE_LOWER]};
         aclk <= avs_writedata_in[`SBA_BIT_ACLK];
      end
   end

   // Every flag lets its set win over a clear in the same cycle.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         fin <= 1'b0;
         ovf <= 1'b0;
         lost <= 1'b0;
      end else begin
         fin <= fin_evt | (fin & ~wr_ctl);
         ovf <= ovf_evt | (ovf & ~wr_ctl);
         lost <= lost_evt | (lost & ~(wr_ctl
                 & ~avs_writedata_in[`SBA_BIT_MODE_UPPER]));
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         txd_out <= 1'b1;
      end else begin
         txd_out <= lost | lost_evt | transmit_shift_in;
      end
   end

   // -------------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------------
   logic [`SBA_IRQ_W-1:0] irq_evt;
   logic [`SBA_IRQ_W-1:0] irq_clr;
   logic [`SBA_IRQ_W-1:0] next_irq_stat;

   assign irq_evt[`SBA_IRQ_FIN] = fin_evt;
   assign irq_evt[`SBA_IRQ_OVF] = ovf_evt;
   assign irq_evt[`SBA_IRQ_LOST] = lost_evt;
   assign irq_clr = wr_stat ? avs_writedata_in[`SBA_IRQ_W-1:0] : '0;
   assign next_irq_stat = irq_evt | (irq_stat & ~irq_clr);

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq_out <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (wr_mask) begin
            irq_mask <= avs_writedata_in[`SBA_IRQ_W-1:0];
         end
         irq_out <= |(next_irq_stat & (wr_mask
                      ? avs_writedata_in[`SBA_IRQ_W-1:0] : irq_mask));
      end
   end

   // -------------------------------------------------------------------
   // Avalon-MM response
   // -------------------------------------------------------------------
   logic [7:0] ctl_rd;

   always_comb begin
      ctl_rd = `SBA_ZERO8;
      ctl_rd[`SBA_BIT_MODE_UPPER] = mode[1];
      ctl_rd[`SBA_BIT_LOST] = lost;
      ctl_rd[`SBA_BIT_MODE_LOWER] = mode[0];
      ctl_rd[`SBA_BIT_ACLK] = aclk;
      ctl_rd[`SBA_BIT_FIN] = fin;
      ctl_rd[`SBA_BIT_RUN] = counting;
      ctl_rd[`SBA_BIT_OVF] = ovf;
      ctl_rd[`SBA_BIT_MSB] = cnt[8];
   end

   // One wait cycle per access; read data is loaded while waiting.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wait_r <= 1'b1;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= `SBA_ZERO32;
      end else begin
         if (bus_req & wait_r) begin
            wait_r <= 1'b0;
            avs_waitrequest_out <= 1'b0;
         end else begin
            wait_r <= 1'b1;
            avs_waitrequest_out <= 1'b1;
         end
         if (avs_read_in & wait_r) begin
            avs_readdata_out <= `SBA_ZERO32;
            if (sba_hit(avs_address_in, `SBA_OFF_CTL)) begin
               avs_readdata_out[7:0] <= ctl_rd;
            end else if (sba_hit(avs_address_in, `SBA_OFF_CNT)) begin
               avs_readdata_out[7:0] <= cnt[7:0];
            end else if (sba_hit(avs_address_in, `SBA_OFF_IRQ_STAT)) begin
               avs_readdata_out[`SBA_IRQ_W-1:0] <= irq_stat;
            end else if (sba_hit(avs_address_in, `SBA_OFF_IRQ_MASK)) begin
               avs_readdata_out[`SBA_IRQ_W-1:0] <= irq_mask;
            end
         end
      end
   end

endmodule

`default_nettype wire

// [sba_arbiter_asserts.sv]
// Purpose: Port-level checks of the bit time arbiter.
// Assumes: Bound to sba_arbiter; one clock, synchronous active-low reset.
// Notes:   Counter values are checked only where a rule fixes them.
`default_nettype none

module sba_arbiter_asserts #(
   parameter int BUS_DIV = 4
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic rxd_in,
   input wire logic transmit_shift_in,
   input wire logic prescaler_tick_in,
   input wire logic txd_out,
   input wire logic irq_out
);
   // -------------------------------------------------------------------
   // Helper state
   // -------------------------------------------------------------------
   logic idle_mode;
   logic done_rd;
   assign done_rd = avs_read_in && !avs_waitrequest_out;

   // Mode codes 00 and 11 both keep the counter at rest.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         idle_mode <= 1'b1;
      end else if (avs_write_in && !avs_waitrequest_out &&
                   avs_address_in == 4'h0 && avs_byteenable_in[0]) begin
         idle_mode <= avs_writedata_in[7] == avs_writedata_in[5];
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_reset_outputs: assert property (disable iff (1'b0)
      !resetn_in |=> avs_waitrequest_out && txd_out && !irq_out)
      else $error("outputs wrong after reset");
   a_wait_one_cycle: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("request not answered after one wait cycle");
   a_wait_back_high: assert property (
      !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   a_wait_quiet_bus: assert property (
      !(avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> avs_waitrequest_out)
      else $error("answer without a request");
   a_txd_source: assert property (
      !txd_out |-> !$past(transmit_shift_in))
      else $error("transmit pin low without low shift output");
   a_unmapped_zero: assert property (
      done_rd && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_upper_bits_zero: assert property (
      done_rd |-> avs_readdata_out[31:8] == 24'h0)
      else $error("read data above byte not zero");
   a_idle_count_zero: assert property (
      done_rd && idle_mode && avs_address_in == 4'h4
      |-> avs_readdata_out[7:0] == 8'h00)
      else $error("counter not held at zero in idle");
   a_lost_forces_txd: assert property (
      done_rd && avs_address_in == 4'h0 && avs_readdata_out[6] |-> txd_out)
      else $error("transmit pin not forced high while lost");
endmodule

bind sba_arbiter sba_arbiter_asserts #(.BUS_DIV(BUS_DIV)) chk_u (
   .mclk_in(mclk_in), .resetn_in(resetn_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in),
   .transmit_shift_in(transmit_shift_in),
   .prescaler_tick_in(prescaler_tick_in), .txd_out(txd_out),
   .irq_out(irq_out));

`default_nettype wire

// [sba_arbiter_bench.sv]
// Purpose: Register-level bench for the bit time arbiter.
// Assumes: Node model and transmit pin share the receive wire.
// Notes:   Counts are checked in a window for sync and tick phase.
`default_nettype none

module sba_arbiter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0, resetn_in = 1'b0;
   logic [3:0] addr = 4'h0, be = 4'hF;
   logic rd = 1'b0, wr = 1'b0, tx_sh = 1'b1, tick = 1'b0, pull = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic waitreq, txd, irq, node_n;
   wire logic rxd;
   logic [1:0] div = 2'h0;
   logic [31:0] idle_codes [2] = '{32'h00, 32'hA0};
   int err_total = 0, checked = 0;

   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      tick <= (div == 2'h2);
   end
   // Wired-AND with pull-up: any node pulling low owns the line.
   assign rxd = txd & node_n;

   sba_arbiter dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .rxd_in(rxd), .transmit_shift_in(tx_sh), .prescaler_tick_in(tick),
      .txd_out(txd), .irq_out(irq));
   sba_bus_node #(.LAG(1)) node_u (.mclk_in(mclk_in), .pull_low_in(pull),
      .line_n_out(node_n));

   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask

   // One edge passes after release so back-to-back calls never
   // assign a strobe twice in one time step.
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge mclk_in);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      rv = rdata;
      if (n >= 20) begin
         err_total++;
         $display("MISMATCH waitrequest expected 0 seen %b", waitreq);
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_rng(input string nm, input int lo, input int hi,
      input logic [7:0] g);
      checked++;
      if ($isunknown(g) || g < lo || g > hi) begin
         err_total++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [3:0] a,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(nm, e, rv);
   endtask

   task automatic rd_cnt(input string nm, input int lo, input int hi);
      bus(1'b0, 4'h4, 32'h0);
      check_rng(nm, lo, hi, rv[7:0]);
   endtask

   task automatic irq_is(input logic e);
      cyc(3);
      check("irq_out", {31'h0, e}, {31'h0, irq});
   endtask

   task automatic fall(input int n);
      pull <= 1'b1;
      cyc(n);
      pull <= 1'b0;
   endtask

   task automatic arb_case(input logic [7:0] c, input int t_on,
      input int t_len, input logic [31:0] e);
      bus(1'b1, 4'h0, {24'h0, c});
      tx_sh <= 1'b0;
      cyc(10);
      tx_sh <= 1'b1;
      cyc(t_on);
      fall(t_len);
      cyc(20);
      rd_chk("ctl_arb", 4'h0, e);
   endtask

   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial begin
      cyc(5);
      resetn_in <= 1'b1;
      cyc(1);
      for (int i = 0; i < 16; i += 2) begin
         rd_chk("reset_read", 4'(i), 32'h0);
      end
      bus(1'b1, 4'h2, 32'hFF);
      be <= 4'h0;
      bus(1'b1, 4'h0, 32'h20);
      be <= 4'hF;
      rd_chk("ctl_refused", 4'h0, 32'h0);
      $display("test reset done");
      foreach (idle_codes[k]) begin
         bus(1'b1, 4'h0, idle_codes[k]);
         fall(20);
         cyc(60);
         rd_chk("ctl_idle", 4'h0, idle_codes[k]);
         rd_cnt("cnt_idle", 0, 0);
      end
      $display("test idle done");
      bus(1'b1, 4'h0, 32'h20);
      cyc(10);
      fall(8);
      cyc(100);
      rd_chk("ctl_running", 4'h0, 32'h24);
      cyc(289);
      fall(8);
      cyc(20);
      rd_chk("ctl_finished", 4'h0, 32'h28);
      rd_cnt("cnt_bus_clk", 98, 102);
      irq_is(1'b0);
      bus(1'b1, 4'hC, 32'h1);
      irq_is(1'b1);
      bus(1'b1, 4'h8, 32'h1);
      irq_is(1'b0);
      bus(1'b1, 4'h0, 32'h20);
      rd_chk("ctl_cleared", 4'h0, 32'h20);
      rd_cnt("cnt_cleared", 0, 0);
      pull <= 1'b1;
      cyc(10);
      bus(1'b1, 4'h0, 32'h30);
      cyc(297);
      pull <= 1'b0;
      cyc(10);
      rd_chk("ctl_break", 4'h0, 32'h38);
      rd_cnt("cnt_prescaled", 47, 53);
      bus(1'b1, 4'h8, 32'h7);
      bus(1'b1, 4'h0, 32'h20);
      fall(8);
      cyc(2100);
      rd_chk("ctl_overflow", 4'h0, 32'h26);
      rd_chk("irq_stat_ovf", 4'h8, 32'h2);
      bus(1'b1, 4'h0, 32'h0);
      rd_chk("ctl_ovf_clear", 4'h0, 32'h0);
      $display("test measurement done");
      bus(1'b1, 4'hC, 32'h4);
      arb_case(8'h80, 150, 110, 32'hC4);
      tx_sh <= 1'b0;
      irq_is(1'b1);
      check("txd_forced", 32'h1, {31'h0, txd});
      bus(1'b1, 4'h0, 32'h80);
      rd_chk("ctl_lost_kept", 4'h0, 32'hC0);
      bus(1'b1, 4'h0, 32'h00);
      rd_chk("ctl_lost_clr", 4'h0, 32'h00);
      check("txd_free", 32'h0, {31'h0, txd});
      bus(1'b1, 4'h8, 32'h7);
      irq_is(1'b0);
      arb_case(8'h90, 20, 60, 32'hD4);
      bus(1'b1, 4'h0, 32'h00);
      arb_case(8'h80, 20, 60, 32'h84);
      $display("test arbitration done");
      bus(1'b1, 4'h0, 32'h80);
      tx_sh <= 1'b0;
      cyc(10);
      tx_sh <= 1'b1;
      cyc(40);
      tx_sh <= 1'b0;
      cyc(20);
      rd_chk("ctl_rearmed", 4'h0, 32'h80);
      rd_cnt("cnt_rearmed", 0, 0);
      $display("test rearm done");
      test_done();
   end

   initial begin
      cyc(20000);
      err_total++;
      $display("MISMATCH watchdog expected end seen hang");
      test_done();
   end
endmodule

`default_nettype wire

// [sba_bus_node.sv]
// Purpose: Model of another node on the shared single-wire bus.
// Assumes: The line has a pull-up; a node can only pull it low.
// Notes:   LAG delays the pull by whole clocks so the node can be slow.
`default_nettype none

module sba_bus_node #(
   parameter int LAG = 1
) (
   input wire logic mclk_in,
   input wire logic pull_low_in,
   output logic line_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pipe = 8'h00;
   always @(posedge mclk_in) begin
      pipe <= {pipe[6:0], pull_low_in};
   end
   assign line_n_out = !pipe[LAG - 1];
endmodule

`default_nettype wire

// [sba_defines.svh]
// Purpose: Register offsets, field positions and timing constants of the
//          serial bit time arbiter.
// Assumes: Included by its bare name before any design file that uses it.
// Notes:   Definitions only.
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define SBA_OFF_CTL 4'h0
`define SBA_OFF_CNT 4'h4
`define SBA_OFF_IRQ_STAT 4'h8
`define SBA_OFF_IRQ_MASK 4'hC

// ---------------------------------------------------------------------
// Control and status field positions
// ---------------------------------------------------------------------
`define SBA_BIT_MODE_UPPER 7
`define SBA_BIT_LOST 6
`define SBA_BIT_MODE_LOWER 5
`define SBA_BIT_ACLK 4
`define SBA_BIT_FIN 3
`define SBA_BIT_RUN 2
`define SBA_BIT_OVF 1
`define SBA_BIT_MSB 0

// ---------------------------------------------------------------------
// Interrupt status and mask field positions
// ---------------------------------------------------------------------
`define SBA_IRQ_FIN 0
`define SBA_IRQ_OVF 1
`define SBA_IRQ_LOST 2
`define SBA_IRQ_W 3

// ---------------------------------------------------------------------
// Mode codes, counts and reset values
// ---------------------------------------------------------------------
`define SBA_MODE_IDLE 2'h0
`define SBA_MODE_MEAS 2'h1
`define SBA_MODE_ARB 2'h2
`define SBA_MODE_RSVD 2'h3
`define SBA_SAMPLE_BUS 9'h038
`define SBA_SAMPLE_PRE 9'h008
`define SBA_CNT_MAX 9'h1FF
`define SBA_CNT_ZERO 9'h000
`define SBA_BUS_DIV 4
// Stages from the transmit pin back to the filtered receive level.
`define SBA_ECHO_W 4
`define SBA_ZERO8 8'h00
`define SBA_ZERO32 32'h00000000

`endif

// [sba_pkg.sv]
// Purpose: Shared types of the serial bit time arbiter.
// Assumes: Compiled before the arbiter module.
// Notes:   Used with explicit package scope only.
`default_nettype none

package sba_pkg;

   // -------------------------------------------------------------------
   // Counter sequencing states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      SBA_IDLE,
      SBA_ARMED,
      SBA_COUNT,
      SBA_STOPPED
   } sba_state_t;

   typedef logic [1:0] sba_mode_t;

endpackage

`default_nettype wire
